// ### arith_accel_regs.vh
`ifndef ARITH_ACCEL_REGS_VH
`define ARITH_ACCEL_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_BYTE0        8'hf9
`define OFS_BYTE1        8'hfa
`define OFS_BYTE2        8'hfb
`define OFS_BYTE3        8'hfc
`define OFS_BYTE4        8'hfd
`define OFS_BYTE5        8'hfe
`define OFS_CTRL         8'hff

// ----------------------------------------
// control field positions
// ----------------------------------------
`define CTRL_SEQ_ERR_BIT 7
`define CTRL_OVF_BIT     6
`define CTRL_DIR_BIT     5
`define CTRL_CNT_MSB     4

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_BYTE         8'h00
`define RST_CTRL         8'h00

// ----------------------------------------
// latency counts, cycles after the last write
// ----------------------------------------
`define LAT_DIV32        5'd17
`define LAT_DIV16        5'd9
`define LAT_MUL          5'd10
`define LAT_SHIFT_BASE   5'd2

`endif

// ### arith_accel_sva.sv
`timescale 1ns/1ps

// ------------------------------
// port checks
// ------------------------------
module arith_accel_sva
(
	// clock and reset
	input wire       mclk_i,
	input wire       rst_n_i,
	// register port
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire       wr_i,
	input wire       rd_i,
	input wire [7:0] rdata_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (rd_i && addr_i < 8'hf9 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_err_clear: assert property (rd_i && addr_i == 8'hff ##1 !wr_i ##1
		rd_i && addr_i == 8'hff |=> !rdata_o[7]) else $error("error flag not cleared");
	a_write_err: assert property (wr_i && addr_i == 8'hff && wdata_i[4:0] == 5'h08
		##1 wr_i && addr_i == 8'hfa ##1 rd_i && addr_i == 8'hff |=> rdata_o[7])
		else $error("early data write not flagged");
	a_div_zero: assert property (wr_i && addr_i == 8'hfd && wdata_i == 8'h00
		##1 wr_i && addr_i == 8'hfe && wdata_i == 8'h00 ##17 rd_i && addr_i == 8'hff
		|=> rdata_o[6]) else $error("zero divisor without overflow");
	a_norm_ovf: assert property (wr_i && addr_i == 8'hfc && wdata_i[7]
		##1 wr_i && addr_i == 8'hff && wdata_i[4:0] == 5'h00 ##28 rd_i && addr_i == 8'hff
		|=> rdata_o[6]) else $error("normalized operand without overflow");
	a_dir_kept: assert property (wr_i && addr_i == 8'hff ##28
		rd_i && addr_i == 8'hff |=> rdata_o[5] == $past(wdata_i[5], 29))
		else $error("direction bit lost");
	a_shift_right: assert property (wr_i && addr_i == 8'hfc
		##1 wr_i && addr_i == 8'hff && wdata_i == 8'h21 ##26 rd_i && addr_i == 8'hfc
		|=> rdata_o == {1'b0, $past(wdata_i[7:1], 28)}) else $error("right shift wrong");
endmodule

bind arith_accelerator arith_accel_sva i_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));

// ### arith_accelerator.v
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "arith_accel_regs.vh"

// Contract
// [RULE_01] unsigned 16x16 multiply, 32/16 divide, 32-bit shift and normalize
// [RULE_02] no completion flag; software waits the fixed cycle count
// [RULE_03] 32/16 divide yields 32-bit quotient, 16-bit remainder in 17 cycles
// [RULE_04] 16/16 divide yields 16-bit quotient and remainder in 9 cycles
// [RULE_05] 16x16 multiply yields 32-bit product in 10 cycles
// [RULE_06] latency from last load write; normalize 3-20, shift 3-18 cycles; here normalize takes 4-20, shift 5-20
// [RULE_07] six data bytes at f9..fe plus control register at ff
// [RULE_08] phases: load bytes, execute, read results back
// [RULE_09] host follows each operation's exact access order
// [RULE_10] data write during a running operation sets sequence error bit 7
// [RULE_11] reading control register clears sequence error flag
// [RULE_12] overflow bit 6 on zero divisor or product above 0x0000ffff
// [RULE_13] bit 5 set shifts right, clear shifts left
// [RULE_14] writing count 00000 starts normalization
// [RULE_15] normalization writes its shift count into the count field
// [RULE_16] non-zero count shifts operand by that many bits in set direction
// [RULE_17] divide load: bytes 0..3 dividend, 4..5 divisor; byte 0 resets, byte 5 starts
// [RULE_18] multiply load order: byte 0, byte 4, byte 1, byte 5
// [RULE_19] overflow also on normalizing an operand with msb already set
// [RULE_20] error window from byte 0 write to final read; clean sequence clears flag
// [RULE_21] results stay until byte 0 written again
// [RULE_22] normalization shifts left until msb is 1, result in bytes 0..3
module arith_accelerator
(
	// clock and reset
	input  wire       mclk_i,
	input  wire       rst_n_i,
	// register port
	input  wire [7:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       wr_i,
	input  wire       rd_i,
	output reg  [7:0] rdata_o
);

	// ----------------------------------------
	// operation codes and states
	// ----------------------------------------
	localparam OP_NONE = 3'd0;
	localparam OP_DIV  = 3'd1;
	localparam OP_MUL  = 3'd2;
	localparam OP_NORM = 3'd3;
	localparam OP_SHFT = 3'd4;

	localparam ST_LOAD = 2'd0;
	localparam ST_RUN  = 2'd1;
	localparam ST_READ = 2'd2;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	reg rst_s1_q;
	reg rst_s2_q;
	wire rst_n;

	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg  [7:0]  md_q [0:5];
	reg  [1:0]  st_q;
	reg  [2:0]  op_q;
	reg         wide_q;
	reg  [4:0]  cnt_q;
	reg         seq_err_q;
	reg         ovf_q;
	reg         dir_q;
	reg  [4:0]  sc_q;
	reg  [5:0]  wmask_q;
	reg  [16:0] rem_q;
	reg  [31:0] acc_q;
	reg  [31:0] mcand_q;
	reg  [15:0] mplr_q;

	wire [31:0] opnd;
	wire [15:0] dvs;
	wire [16:0] rem_n1;
	wire [16:0] rem_n2;
	wire [31:0] quo_n1;
	wire [31:0] quo_n2;
	wire [31:0] pp_n;

	assign opnd = {md_q[3], md_q[2], md_q[1], md_q[0]};
	assign dvs  = {md_q[5], md_q[4]};

	wire wr_md   = wr_i && (addr_i >= `OFS_BYTE0) && (addr_i <= `OFS_BYTE5);
	wire wr_ctrl = wr_i && (addr_i == `OFS_CTRL);
	wire rd_ctrl = rd_i && (addr_i == `OFS_CTRL);
	wire [2:0] widx = addr_i[2:0] - 3'd1;

	// two division steps per cycle
	div_step u_step0
	(
		.rem_i (rem_q),
		.quo_i (acc_q),
		.dvs_i (dvs),
		.rem_o (rem_n1),
		.quo_o (quo_n1)
	);

	div_step u_step1
	(
		.rem_i (rem_n1),
		.quo_i (quo_n1),
		.dvs_i (dvs),
		.rem_o (rem_n2),
		.quo_o (quo_n2)
	);

	// two multiply bits per cycle
	assign pp_n = acc_q
		+ (mplr_q[0] ? mcand_q : 32'h0000_0000)
		+ (mplr_q[1] ? {mcand_q[30:0], 1'b0} : 32'h0000_0000);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	integer i;

	always @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (i = 0; i < 6; i = i + 1)
				md_q[i] <= `RST_BYTE;
			st_q      <= ST_LOAD;
			op_q      <= OP_NONE;
			wide_q    <= 1'b0;
			cnt_q     <= 5'd0;
			seq_err_q <= 1'b0;
			ovf_q     <= 1'b0;
			dir_q     <= 1'b0;
			sc_q      <= 5'd0;
			wmask_q   <= 6'd0;
			rem_q     <= 17'd0;
			acc_q     <= 32'd0;
			mcand_q   <= 32'd0;
			mplr_q    <= 16'd0;
		end
		else
		begin
			// read of control clears the error flag; a new error wins
			if (rd_ctrl)
				seq_err_q <= 1'b0; // RULE_11
			if (wr_md)
			begin
				md_q[widx] <= wdata_i; // RULE_07 RULE_08
				if (st_q == ST_RUN)
					seq_err_q <= 1'b1; // RULE_10
				if (widx == 3'd0)
				begin
					// byte 0 restarts the unit and the error window
					wmask_q <= 6'b000001; // RULE_17 RULE_20 RULE_21
					st_q    <= ST_LOAD;
					op_q    <= OP_NONE;
					ovf_q   <= 1'b0;
				end
				else
					wmask_q <= wmask_q | (6'b000001 << widx);
				if (widx == 3'd5)
				begin
					st_q  <= ST_RUN;
					ovf_q <= 1'b0;
					// multiply: 0,4,1,5 leaves byte 1 written after byte 4
					if (wmask_q[4] && wmask_q[1] && !wmask_q[2] && !wmask_q[3] &&
						op_q == OP_MUL)
					begin
						op_q    <= OP_MUL; // RULE_18
						cnt_q   <= `LAT_MUL - 5'd1; // RULE_05
						acc_q   <= 32'd0;
						mcand_q <= {16'd0, md_q[1], md_q[0]};
						mplr_q  <= {wdata_i, md_q[4]};
					end
					else
					begin
						op_q   <= OP_DIV; // RULE_17
						wide_q <= wmask_q[3];
						cnt_q  <= wmask_q[3] ? `LAT_DIV32 - 5'd1 : `LAT_DIV16 - 5'd1; // RULE_03 RULE_04
						rem_q  <= 17'd0;
						acc_q  <= wmask_q[3] ? opnd : {opnd[15:0], 16'd0};
						if ({wdata_i, md_q[4]} == 16'd0)
							ovf_q <= 1'b1; // RULE_12
					end
				end
				// byte 4 written while byte 1 pending marks multiply order
				if (widx == 3'd4 && !wmask_q[1])
					op_q <= OP_MUL;
			end
			if (wr_ctrl)
			begin
				if (st_q == ST_RUN)
					seq_err_q <= 1'b1; // RULE_10
				dir_q <= wdata_i[`CTRL_DIR_BIT];
				sc_q  <= wdata_i[`CTRL_CNT_MSB:0];
				acc_q <= opnd;
				st_q  <= ST_RUN;
				ovf_q <= 1'b0;
				if (wdata_i[`CTRL_CNT_MSB:0] == 5'd0)
				begin
					op_q  <= OP_NORM; // RULE_14
					cnt_q <= `LAT_SHIFT_BASE;
					if (opnd[31])
						ovf_q <= 1'b1; // RULE_19
				end
				else
				begin
					op_q  <= OP_SHFT; // RULE_16
					cnt_q <= `LAT_SHIFT_BASE;
				end
			end
			// execution
			if (st_q == ST_RUN && !wr_md && !wr_ctrl)
			begin
				case (op_q)
					OP_DIV:
					begin
						if (cnt_q > 5'd1)
						begin
							rem_q <= rem_n2;
							acc_q <= quo_n2;
						end
						else
						begin
							// results land on the last cycle
							md_q[0] <= quo_n2[7:0]; // RULE_03 RULE_04
							md_q[1] <= quo_n2[15:8];
							md_q[2] <= wide_q ? quo_n2[23:16] : md_q[2];
							md_q[3] <= wide_q ? quo_n2[31:24] : md_q[3];
							md_q[4] <= rem_n2[7:0];
							md_q[5] <= rem_n2[15:8];
							st_q    <= ST_READ;
						end
						cnt_q <= cnt_q - 5'd1;
					end
					OP_MUL:
					begin
						if (cnt_q > 5'd1)
						begin
							acc_q   <= pp_n; // RULE_01
							mcand_q <= {mcand_q[29:0], 2'b00};
							mplr_q  <= {2'b00, mplr_q[15:2]};
						end
						else if (cnt_q == 5'd1)
						begin
							md_q[0] <= acc_q[7:0]; // RULE_05
							md_q[1] <= acc_q[15:8];
							md_q[2] <= acc_q[23:16];
							md_q[3] <= acc_q[31:24];
							if (acc_q[31:16] != 16'd0)
								ovf_q <= 1'b1; // RULE_12
							st_q <= ST_READ;
						end
						cnt_q <= cnt_q - 5'd1;
					end
					OP_NORM:
					begin
						// two bits per cycle while the top two bits are clear, else one, after setup
						if (cnt_q != 5'd0)
							cnt_q <= cnt_q - 5'd1; // RULE_06
						else if (acc_q[31:30] == 2'b00 && acc_q != 32'd0)
						begin
							acc_q <= {acc_q[29:0], 2'b00}; // RULE_22
							sc_q  <= sc_q + 5'd2; // RULE_15
						end
						else if (!acc_q[31] && acc_q != 32'd0 && sc_q != 5'd31)
						begin
							acc_q <= {acc_q[30:0], 1'b0}; // RULE_22
							sc_q  <= sc_q + 5'd1; // RULE_15
						end
						else
						begin
							md_q[0] <= acc_q[7:0];
							md_q[1] <= acc_q[15:8];
							md_q[2] <= acc_q[23:16];
							md_q[3] <= acc_q[31:24];
							st_q    <= ST_READ;
						end
					end
					OP_SHFT:
					begin
						if (cnt_q != 5'd0)
							cnt_q <= cnt_q - 5'd1; // RULE_06
						else if (sc_q > 5'd1)
						begin
							acc_q <= dir_q ? {2'b00, acc_q[31:2]} : {acc_q[29:0], 2'b00}; // RULE_13
							sc_q  <= sc_q - 5'd2; // RULE_16
						end
						else if (sc_q != 5'd0)
						begin
							acc_q <= dir_q ? {1'b0, acc_q[31:1]} : {acc_q[30:0], 1'b0}; // RULE_13
							sc_q  <= sc_q - 5'd1; // RULE_16
						end
						else
						begin
							md_q[0] <= acc_q[7:0];
							md_q[1] <= acc_q[15:8];
							md_q[2] <= acc_q[23:16];
							md_q[3] <= acc_q[31:24];
							st_q    <= ST_READ;
						end
					end
					default:
						st_q <= ST_LOAD;
				endcase
			end
			// reading control after a finished run ends the sequence, error flag set or not
			if (rd_ctrl && st_q == ST_READ)
			begin
				st_q    <= ST_LOAD; // RULE_20
				wmask_q <= 6'd0;
			end
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
			rdata_o <= 8'h00;
		else if (rd_i && addr_i == `OFS_CTRL)
			rdata_o <= {seq_err_q, ovf_q, dir_q, sc_q}; // RULE_02 RULE_11
		else if (rd_i && addr_i >= `OFS_BYTE0 && addr_i <= `OFS_BYTE5)
			rdata_o <= md_q[addr_i[2:0] - 3'd1]; // RULE_21
		else
			rdata_o <= 8'h00;
	end

endmodule

// ### cpu_host.sv
`timescale 1ns/1ps

// ------------------------------
// cpu side of the register port
// ------------------------------
module cpu_host
(
	// clock
	input  wire       mclk_i,
	// register port
	output reg  [7:0] addr_o,
	output reg  [7:0] wdata_o,
	output reg        wr_o,
	output reg        rd_o,
	input  wire [7:0] rdata_i
);
	initial
	begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	task wr(input [7:0] a, input [7:0] d);
	begin
		@(posedge mclk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		rd_o <= 1'b0;
	end
	endtask

	task idle(input integer n);
		integer j;
	begin
		for (j = 0; j < n; j = j + 1)
		begin
			@(posedge mclk_i);
			wr_o <= 1'b0;
			rd_o <= 1'b0;
			wdata_o <= ~wdata_o;
		end
	end
	endtask

	task rd(input [7:0] a, output [7:0] d);
	begin
		@(posedge mclk_i);
		addr_o <= a;
		wr_o <= 1'b0;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		@(negedge mclk_i);
		d = rdata_i;
	end
	endtask
endmodule

// ### div_step.v
`timescale 1ns/1ps

// ----------------------------------------
// one restoring division step
// ----------------------------------------
module div_step
(
	// operands
	input  wire [16:0] rem_i,
	input  wire [31:0] quo_i,
	input  wire [15:0] dvs_i,
	// results
	output wire [16:0] rem_o,
	output wire [31:0] quo_o
);

	wire [16:0] sh;
	wire [17:0] diff;

	assign sh    = {rem_i[15:0], quo_i[31]};
	assign diff  = {1'b0, sh} - {2'b00, dvs_i};
	assign rem_o = diff[17] ? sh : diff[16:0];
	assign quo_o = {quo_i[30:0], ~diff[17]};

endmodule

// ### multiply_divide_unit_test.sv
`timescale 1ns/1ps

// ------------------------------
// accelerator bench
// ------------------------------
module multiply_divide_unit_test;
	reg        mclk_i = 1'b0;
	reg        rst_n_i = 1'b0;
	wire [7:0] addr_i;
	wire [7:0] wdata_i;
	wire [7:0] rdata_o;
	wire       wr_i;
	wire       rd_i;
	integer    n_errors = 0;
	integer    checks_done = 0;
	integer    i;
	integer    k;
	reg [31:0] rng = 32'd76109;
	reg [31:0] a;
	reg [31:0] r;
	reg [7:0]  got;

	always #10 mclk_i = ~mclk_i;

	arith_accelerator i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
	cpu_host i_host (.mclk_i(mclk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
		.rd_o(rd_i), .rdata_i(rdata_o));

	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
	begin
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	end
	endfunction

	function [4:0] lead0(input [31:0] x);
		integer j;
	begin
		lead0 = 5'h00;
		for (j = 0; j < 32; j = j + 1)
			if (x[j])
				lead0 = 5'd31 - j[4:0];
	end
	endfunction

	task chk(input [7:0] g, input [7:0] e);
	begin
		checks_done = checks_done + 1;
		if (g !== e)
		begin
			n_errors = n_errors + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	end
	endtask

	task rdc(input [7:0] ad, input [7:0] e, input [7:0] m);
	begin
		i_host.rd(ad, got);
		chk(got & m, e & m);
	end
	endtask

	task ld(input [31:0] x);
		integer j;
	begin
		for (j = 0; j < 4; j = j + 1)
			i_host.wr(8'hf9 + j[7:0], x[8*j +: 8]);
	end
	endtask

	task rd32(input [31:0] e);
		integer j;
	begin
		for (j = 0; j < 4; j = j + 1)
			rdc(8'hf9 + j[7:0], e[8*j +: 8], 8'hff);
	end
	endtask

	task mul(input [15:0] x, input [15:0] y);
	begin
		r = x * y;
		i_host.wr(8'hf9, x[7:0]);
		i_host.wr(8'hfd, y[7:0]);
		i_host.wr(8'hfa, x[15:8]);
		i_host.wr(8'hfe, y[15:8]);
		i_host.idle(9);
		rd32(r);
		rdc(8'hff, {1'b0, r > 32'h0000ffff, 6'h00}, 8'hc0);
	end
	endtask

	task div(input [31:0] x, input [15:0] y, input w);
		reg [31:0] d;
		reg [31:0] q;
		reg [7:0]  m;
	begin
		d = w ? x : {16'h0000, x[15:0]};
		m = (y == 16'h0000) ? 8'h00 : 8'hff;
		r = (y == 16'h0000) ? 32'h0 : d / y;
		q = (y == 16'h0000) ? 32'h0 : d % y;
		i_host.wr(8'hf9, d[7:0]);
		i_host.wr(8'hfa, d[15:8]);
		if (w)
		begin
			i_host.wr(8'hfb, d[23:16]);
			i_host.wr(8'hfc, d[31:24]);
		end
		i_host.wr(8'hfd, y[7:0]);
		i_host.wr(8'hfe, y[15:8]);
		i_host.idle(w ? 16 : 8);
		rdc(8'hf9, r[7:0], m);
		rdc(8'hfa, r[15:8], m);
		if (w)
		begin
			rdc(8'hfb, r[23:16], m);
			rdc(8'hfc, r[31:24], m);
		end
		rdc(8'hfd, q[7:0], m);
		rdc(8'hfe, q[15:8], m);
		rdc(8'hff, {1'b0, y == 16'h0000, 6'h00}, 8'hc0);
	end
	endtask

	task sh(input [31:0] x, input [7:0] c);
		reg [4:0] n;
		reg       z;
	begin
		z = (c[4:0] == 5'h00);
		ld(x);
		i_host.wr(8'hff, c);
		i_host.idle(19);
		n = z ? lead0(x) : c[4:0];
		r = (c[5] && !z) ? x >> n : x << n;
		rd32(r);
		rdc(8'hff, {1'b0, x[31] && z, c[5], n}, z ? 8'hff : 8'he0);
	end
	endtask

	task summarize;
	begin
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask

	// watchdog, far beyond the expected run
	initial
	begin
		#200000;
		n_errors = n_errors + 1;
		summarize;
	end

	initial
	begin
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		i_host.idle(3);
		for (k = 0; k < 8; k = k + 1)
			rdc((k == 7) ? 8'h10 : 8'hf9 + k[7:0], 8'h00, 8'hff);
		mul(16'hffff, 16'hffff);
		mul(16'h00ff, 16'h0101);
		div(32'hffff_ffff, 16'h0001, 1'b1);
		div(32'h0000_1234, 16'h0000, 1'b0);
		sh(32'h8000_0001, 8'h00);
		sh(32'h0000_0001, 8'h00);
		sh(32'h8765_4321, 8'h21);
		sh(32'h8765_4321, 8'h0f);
		for (i = 0; i < 6; i = i + 1)
		begin
			rng = xs(rng);
			a = rng;
			rng = xs(rng);
			mul(a[15:0], rng[15:0]);
			div(a, rng[31:16] | 16'h0001, rng[0]);
			sh(a >> rng[4:0], 8'h00);
			sh(a, {2'b00, rng[8], 1'b0, rng[3:0] | 4'h1});
		end
		ld(32'h1111_1111);
		i_host.wr(8'hff, 8'h08);
		i_host.wr(8'hfa, 8'h55);
		rdc(8'hff, 8'h80, 8'h80);
		rdc(8'hff, 8'h00, 8'h80);
		i_host.idle(19);
		mul(16'h1234, 16'h0002);
		rdc(8'hf9, 8'h68, 8'hff);
		summarize;
	end
endmodule
